// ==== hdl/vdet_ctrl.sv ====
`timescale 1ns/1ps
`include "vdet_defines.svh"
module vdet_ctrl #(
	parameter int IRQ_DELAY_CYC = `VDET_IRQ_DELAY_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire vdet_pkg::vdet_bus_req_type bus_i,
	output logic [7:0] rdata_o,
	input wire logic cmp_low_i,
	input wire logic idle_i,
	output vdet_pkg::vdet_ana_type ana_o,
	output logic [11:0] threshold_mv_o,
	output logic low_supply_status_o,
	output logic irq_o,
	output logic wake_o
);
	import vdet_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic sel_ctrl, sel_status, sel_mask, sel_set;
	logic wr_en, rd_en;

	always_comb
	begin
		sel_ctrl = bus_i.addr == `VDET_OFS_CTRL;
		sel_status = bus_i.addr == `VDET_OFS_IRQ_STATUS;
		sel_mask = bus_i.addr == `VDET_OFS_IRQ_MASK;
		sel_set = bus_i.addr == `VDET_OFS_IRQ_SET;
		wr_en = ce_i && bus_i.wr;
		rd_en = ce_i && bus_i.rd;
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic enable_ff, nxt_enable;
	logic [2:0] thr_ff, nxt_thr;
	logic [11:0] mv_ff, nxt_mv;

	function automatic logic [11:0] level_mv(input logic [2:0] code);
		logic [11:0] mv;
		unique case (code)
			3'h0: mv = `VDET_MV_0;
			3'h1: mv = `VDET_MV_1;
			3'h2: mv = `VDET_MV_2;
			3'h3: mv = `VDET_MV_3;
			3'h4: mv = `VDET_MV_4;
			3'h5: mv = `VDET_MV_5;
			3'h6: mv = `VDET_MV_6;
			3'h7: mv = `VDET_MV_7;
		endcase
		return mv;
	endfunction : level_mv

	// Bits 7, 6, 5 and 3 of a write have no storage and are dropped.
	always_comb
	begin
		nxt_enable = enable_ff;
		nxt_thr = thr_ff;
		if (wr_en && sel_ctrl)
		begin
			nxt_enable = bus_i.wdata[`VDET_BIT_ENABLE];
			nxt_thr = bus_i.wdata[`VDET_THR_MSB:0];
		end
		nxt_mv = level_mv(nxt_thr);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			enable_ff <= 1'(`VDET_CTRL_RESET >> `VDET_BIT_ENABLE);
			thr_ff <= 3'h0;
			mv_ff <= `VDET_MV_0;
		end
		else
		begin
			enable_ff <= nxt_enable;
			thr_ff <= nxt_thr;
			mv_ff <= nxt_mv;
		end
	end

	// ----------------------------------------------------------------
	// Comparator path
	// ----------------------------------------------------------------
	logic cmp_sync;
	logic status_ff, nxt_status;
	logic fire;

	vdet_sync #(
		.WIDTH(1)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.async_i(cmp_low_i),
		.sync_o(cmp_sync)
	);

	// Idle is deliberately not an input here: the detector must keep
	// comparing through idle, otherwise it could never wake the core.
	always_comb
	begin
		nxt_status = status_ff;
		if (ce_i)
			nxt_status = enable_ff && cmp_sync;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			status_ff <= 1'h0;
		else
			status_ff <= nxt_status;
	end

	vdet_delay #(
		.CYCLES(IRQ_DELAY_CYC)
	) u_delay (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.run_i(status_ff),
		.fire_o(fire)
	);

	// ----------------------------------------------------------------
	// Request flag, mask, interrupt and wake-up
	// ----------------------------------------------------------------
	logic flag_ff, nxt_flag;
	logic mask_ff, nxt_mask;
	logic irq_ff, nxt_irq;
	logic wake_ff, nxt_wake;
	logic flag_clr, flag_set;

	// A hardware or software set in the same cycle as a clear wins.
	always_comb
	begin
		flag_clr = wr_en && sel_status && bus_i.wdata[`VDET_BIT_FLAG];
		flag_set = (ce_i && fire) ||
			(wr_en && sel_set && bus_i.wdata[`VDET_BIT_FLAG]);
		nxt_flag = (flag_ff && !flag_clr) || flag_set;
		nxt_mask = mask_ff;
		if (wr_en && sel_mask)
			nxt_mask = bus_i.wdata[`VDET_BIT_FLAG];
		nxt_irq = ce_i ? (nxt_flag && nxt_mask) : irq_ff;
		nxt_wake = wake_ff;
		if (ce_i)
			nxt_wake = nxt_flag && !flag_ff && idle_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flag_ff <= `VDET_IRQ_RESET;
			mask_ff <= `VDET_IRQ_RESET;
			irq_ff <= 1'h0;
			wake_ff <= 1'h0;
		end
		else
		begin
			flag_ff <= nxt_flag;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
			wake_ff <= nxt_wake;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] rdata_ff, nxt_rdata;

	// Unmapped addresses read as zero; data stand for one enabled cycle only and hold while ce_i is low.
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (!ce_i)
			nxt_rdata = rdata_ff;
		else if (rd_en)
		begin
			if (sel_ctrl)
				nxt_rdata = {2'h0, status_ff, enable_ff, 1'h0, thr_ff};
			else if (sel_status)
				nxt_rdata = {7'h00, flag_ff};
			else if (sel_mask)
				nxt_rdata = {7'h00, mask_ff};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign rdata_o = rdata_ff;
	assign ana_o = '{power: enable_ff, threshold_select: thr_ff};
	assign threshold_mv_o = mv_ff;
	assign low_supply_status_o = status_ff;
	assign irq_o = irq_ff;
	assign wake_o = wake_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_ctrl_read;
		rd_en && sel_ctrl;
	endsequence

	sequence s_flag_rise_idle;
		ce_i && !flag_ff && idle_i ##1 flag_ff;
	endsequence

	a_unused_bits_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_ctrl_read |=> rdata_ff[7:6] == 2'h0 && !rdata_ff[3])
		else $error("unimplemented control bits read nonzero");

	a_status_readback: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_ctrl_read |=> rdata_ff[`VDET_BIT_STATUS] == $past(status_ff))
		else $error("status bit readback wrong");

	a_enable_write: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_en && sel_ctrl) |=>
			ana_o.power == $past(bus_i.wdata[`VDET_BIT_ENABLE]))
		else $error("enable bit not taken from write");

	a_level_map: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(thr_ff == 3'h5 |-> mv_ff == `VDET_MV_5) and
		(thr_ff == 3'h0 |-> mv_ff == `VDET_MV_0) and
		(thr_ff == 3'h7 |-> mv_ff == `VDET_MV_7))
		else $error("trip level does not match threshold code");

	a_sync_latency: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && enable_ff && cmp_low_i) ##1 (ce_i && enable_ff)
			##1 (ce_i && enable_ff) |=> status_ff)
		else $error("comparator not seen after two stages");

	a_disable_clears: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !enable_ff) |=> !status_ff)
		else $error("status high while detector disabled");

	a_idle_runs: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && idle_i && enable_ff && cmp_sync) |=> status_ff)
		else $error("detector stopped during idle");

	a_flag_sticky: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_ff && !flag_clr) |=> flag_ff)
		else $error("request flag dropped without a clear");

	a_sw_set_flag: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_en && sel_set && bus_i.wdata[`VDET_BIT_FLAG] && !idle_i) |=>
			flag_ff && !wake_ff)
		else $error("software preset of flag failed or woke");

	a_wake_on_rise: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_flag_rise_idle |-> wake_ff)
		else $error("rising flag in idle did not wake");

	a_wake_no_mask: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !mask_ff && !flag_ff && idle_i && fire) |=> wake_ff)
		else $error("wake-up gated by interrupt enable");

	a_irq_level: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		ce_i |=> irq_o == (flag_ff && mask_ff))
		else $error("interrupt output disagrees with flag and mask");

	a_flag_clear: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_clr && !flag_set) |=> !flag_ff)
		else $error("request flag not cleared by a one");

	a_wake_pulse: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && wake_o) |=> !wake_o)
		else $error("wake pulse longer than one cycle");

	a_rdata_one_cycle: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !rd_en) |=> rdata_o == 8'h00)
		else $error("read data held past its cycle");

	a_ce_freeze: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(rdata_o) && $stable(irq_o) &&
			$stable(wake_o) && $stable(ana_o) && $stable(flag_ff))
		else $error("state moved while clock enable low");

endmodule : vdet_ctrl

// ==== hdl/vdet_defines.svh ====
`ifndef VDET_DEFINES_SVH
`define VDET_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VDET_OFS_CTRL 8'h00
`define VDET_OFS_IRQ_STATUS 8'h01
`define VDET_OFS_IRQ_MASK 8'h02
`define VDET_OFS_IRQ_SET 8'h03

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define VDET_BIT_STATUS 5
`define VDET_BIT_ENABLE 4
`define VDET_THR_MSB 2
`define VDET_BIT_FLAG 0
`define VDET_CTRL_RESET 8'h00
`define VDET_IRQ_RESET 1'h0

// ----------------------------------------------------------------
// Trip levels in millivolts, indexed by the threshold code
// ----------------------------------------------------------------
`define VDET_MV_0 12'h76C
`define VDET_MV_1 12'h7D0
`define VDET_MV_2 12'h898
`define VDET_MV_3 12'h960
`define VDET_MV_4 12'hAF0
`define VDET_MV_5 12'hB54
`define VDET_MV_6 12'hBB8
`define VDET_MV_7 12'hCE4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VDET_CLK_PERIOD_PS 8000
`define VDET_IRQ_DELAY_NS 15000
`define VDET_IRQ_DELAY_CYC \
	((`VDET_IRQ_DELAY_NS * 1000 + `VDET_CLK_PERIOD_PS - 1) / \
	`VDET_CLK_PERIOD_PS)

`endif

// ==== hdl/vdet_pkg.sv ====
package vdet_pkg;

	// ----------------------------------------------------------------
	// Register bus request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} vdet_bus_req_type;

	// ----------------------------------------------------------------
	// Controls toward the analog comparator and reference
	// ----------------------------------------------------------------
	typedef struct packed {
		logic power;
		logic [2:0] threshold_select;
	} vdet_ana_type;

	typedef enum logic [1:0] {
		ST_WAIT,
		ST_COUNT,
		ST_DONE
	} vdet_dly_state_type;

endpackage : vdet_pkg

// ==== hdl/vdet_sync.sv ====
`timescale 1ns/1ps
module vdet_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import vdet_pkg::*;

	generate
		if (WIDTH < 1)
		begin : g_chk
			$error("vdet_sync: WIDTH must be at least 1");
		end
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_ff, sync_ff, nxt_meta, nxt_sync;
			always_comb
			begin
				nxt_meta = ce_i ? async_i[i] : meta_ff;
				nxt_sync = ce_i ? meta_ff : sync_ff;
			end
			always_ff @(posedge clk_i)
			begin
				if (!rst_n_i)
				begin
					meta_ff <= 1'h0;
					sync_ff <= 1'h0;
				end
				else
				begin
					meta_ff <= nxt_meta;
					sync_ff <= nxt_sync;
				end
			end
			assign sync_o[i] = sync_ff;
		end
	endgenerate

endmodule : vdet_sync

// ==== hdl/vdet_delay.sv ====
`timescale 1ns/1ps
module vdet_delay #(
	parameter int CYCLES = 1875
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic run_i,
	output logic fire_o
);
	import vdet_pkg::*;

	generate
		if (CYCLES < 1 || CYCLES > 65535)
		begin : g_chk
			$error("vdet_delay: CYCLES must be 1 to 65535");
		end
	endgenerate

	localparam logic [15:0] LAST = 16'(CYCLES - 1);

	vdet_dly_state_type state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic fire_ff, nxt_fire;

	// One pulse per low-supply episode; a glitch-free rearm needs run low.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_fire = 1'h0;
		if (!ce_i)
			nxt_fire = fire_ff;
		else if (!run_i)
		begin
			nxt_state = ST_WAIT;
			nxt_cnt = 16'h0000;
		end
		else
		begin
			unique case (state_ff)
				ST_WAIT, ST_COUNT:
				begin
					if (cnt_ff == LAST)
					begin
						nxt_fire = 1'h1;
						nxt_state = ST_DONE;
					end
					else
					begin
						nxt_cnt = cnt_ff + 16'h0001;
						nxt_state = ST_COUNT;
					end
				end
				ST_DONE:
					nxt_state = ST_DONE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_WAIT;
			cnt_ff <= 16'h0000;
			fire_ff <= 1'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			fire_ff <= nxt_fire;
		end
	end

	assign fire_o = fire_ff;

	a_fire_after_delay: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(fire_ff) |-> $past(cnt_ff) == LAST && $past(run_i))
		else $error("delay fired before full count");

	a_drop_resets_count: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !run_i) |=> cnt_ff == 16'h0000 && !fire_ff)
		else $error("counter not cleared when run dropped");

endmodule : vdet_delay

// ==== test/vdet_ana_model.sv ====
`timescale 1ns/1ps
module vdet_ana_model (
	input wire logic clk_i,
	input wire vdet_pkg::vdet_ana_type ana_i,
	input wire logic [11:0] supply_mv_i,
	output logic cmp_low_o
);
	import vdet_pkg::*;
	localparam logic [11:0] TRIP_MV [8] = '{12'h76C, 12'h7D0, 12'h898,
		12'h960, 12'hAF0, 12'hB54, 12'hBB8, 12'hCE4};
	logic junk_ff = 1'b0;

	// ------------------------------------
	// Comparator
	// ------------------------------------
	// An unpowered comparator has no defined output, so it toggles here.
	// A clean low would hide a missing power gate in the logic.
	always_ff @(posedge clk_i)
	begin
		junk_ff <= ~junk_ff;
	end

	always_comb
	begin
		if (ana_i.power)
			cmp_low_o = supply_mv_i < TRIP_MV[ana_i.threshold_select];
		else
			cmp_low_o = junk_ff;
	end
endmodule : vdet_ana_model

// ==== test/tb_vdet_ctrl.sv ====
`timescale 1ns/1ps
module tb_vdet_ctrl;
	import vdet_pkg::*;
	localparam int N = 4;
	localparam logic [11:0] TRIP_MV [8] = '{12'h76C, 12'h7D0, 12'h898,
		12'h960, 12'hAF0, 12'hB54, 12'hBB8, 12'hCE4};
	logic clk_i, rst_n_i, ce_i, idle_i, cmp_low, status, irq, wake;
	vdet_bus_req_type bus;
	vdet_ana_type ana;
	logic [7:0] rdata, w;
	logic [11:0] thr_mv, supply;
	logic [2:0] code;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed, t_st, t_wk, t_irq, n_wk, n_hi;

	vdet_ctrl #(.IRQ_DELAY_CYC(N)) vdet_ctrl_i (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .ce_i(ce_i), .bus_i(bus), .rdata_o(rdata),
		.cmp_low_i(cmp_low), .idle_i(idle_i), .ana_o(ana),
		.threshold_mv_o(thr_mv), .low_supply_status_o(status),
		.irq_o(irq), .wake_o(wake));
	vdet_ana_model vdet_ana_model_i (.clk_i(clk_i), .ana_i(ana),
		.supply_mv_i(supply), .cmp_low_o(cmp_low));

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ------------------------------------
	// Helpers
	// ------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Expected control readback: bits 7, 6 and 3 always read zero.
	function automatic logic [7:0] ctrl_exp(input logic st, input logic en,
		input logic [2:0] thr);
		return {2'h0, st, en, 1'h0, thr};
	endfunction : ctrl_exp

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus <= {a, d, 2'b10};
		@(posedge clk_i);
		bus.wr <= 1'b0;
	endtask : bus_write

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge clk_i);
		bus <= {a, 8'h00, 2'b01};
		@(posedge clk_i);
		bus.rd <= 1'b0;
		@(negedge clk_i);
		check(what, 16'(rdata), 16'(exp));
	endtask : rd_chk

	// Moves the supply, then times status, wake and interrupt edges.
	task automatic episode(input logic [11:0] mv);
		t_st = 0;
		t_wk = 0;
		t_irq = 0;
		n_wk = 0;
		@(posedge clk_i);
		supply <= mv;
		for (int i = 1; i <= 16; i++)
		begin
			@(negedge clk_i);
			if (status === 1'b1 && t_st == 0) t_st = i;
			if (wake === 1'b1 && t_wk == 0) t_wk = i;
			if (irq === 1'b1 && t_irq == 0) t_irq = i;
			if (wake === 1'b1) n_wk++;
		end
	endtask : episode

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		tally_and_finish();
	end

	// ------------------------------------
	// Sequence
	// ------------------------------------
	initial
	begin
		seed = 32'hfb7b;
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		idle_i = 1'b0;
		bus = '0;
		supply = 12'hFFF;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		check("thr_mv reset", 16'(thr_mv), 16'h076C);
		rd_chk("ctrl reset", 8'h00, 8'h00);
		rd_chk("mask reset", 8'h02, 8'h00);
		bus_write(8'h10, 8'hFF);
		rd_chk("unmapped", 8'h10, 8'h00);
		rd_chk("ctrl kept", 8'h00, 8'h00);
		rd_chk("set reg", 8'h03, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			w = (8'($random(seed)) & 8'hE8) | 8'h10 | 8'(c);
			bus_write(8'h00, w);
			@(negedge clk_i);
			check("power", 16'(ana.power), 16'h0001);
			check("thr code", 16'(ana.threshold_select), 16'(c));
			check("thr mv", 16'(thr_mv), 16'(TRIP_MV[c]));
			repeat (4) @(posedge clk_i);
			rd_chk("ctrl", 8'h00, ctrl_exp(1'b0, 1'b1, 3'(c)));
		end
		bus_write(8'h00, 8'h07);
		@(negedge clk_i);
		check("power off", 16'(ana.power), 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			code = 3'($random(seed));
			bus_write(8'h02, {7'h00, k[0]});
			bus_write(8'h00, {5'h02, code});
			repeat (4) @(posedge clk_i);
			idle_i <= 1'b1;
			episode(TRIP_MV[code] - 12'd1 - 12'({$random(seed)} % 200));
			check("status rise", 16'(t_st), 16'h0004);
			check("delay", 16'(t_wk - t_st inside {N, N + 1}), 16'h0001);
			check("wake width", 16'(n_wk), 16'h0001);
			check("irq rise", 16'(t_irq), 16'(k[0] ? t_wk : 0));
			rd_chk("status bit", 8'h00, ctrl_exp(1'b1, 1'b1, code));
			@(posedge clk_i);
			idle_i <= 1'b0;
			episode(12'hFFF);
			check("status fall", 16'(status), 16'h0000);
			rd_chk("flag kept", 8'h01, 8'h01);
			check("irq kept", 16'(irq), 16'(k[0]));
			bus_write(8'h01, 8'h01);
			rd_chk("flag clear", 8'h01, 8'h00);
			check("irq clear", 16'(irq), 16'h0000);
		end
		// A supply hovering at the trip level toggles the status bit but
		// never holds it long enough to raise the request flag.
		n_hi = 0;
		for (int h = 0; h < 12; h++)
		begin
			@(posedge clk_i);
			supply <= h[0] ? 12'hFFF : 12'h400;
			@(negedge clk_i);
			if (status === 1'b1) n_hi++;
		end
		check("hover toggles", 16'(n_hi > 0), 16'h0001);
		rd_chk("hover flag", 8'h01, 8'h00);
		// Presetting the flag must mask the next low-supply wake-up.
		bus_write(8'h03, 8'h01);
		idle_i <= 1'b1;
		episode(12'h400);
		check("preset wake", 16'(n_wk), 16'h0000);
		@(posedge clk_i);
		idle_i <= 1'b0;
		episode(12'hFFF);
		bus_write(8'h01, 8'h01);
		@(posedge clk_i);
		supply <= 12'h400;
		repeat (3) @(posedge clk_i);
		bus_write(8'h00, {5'h00, code});
		// Status may stand one more cycle after the disabling write.
		@(posedge clk_i);
		n_wk = 0;
		repeat (12)
		begin
			@(negedge clk_i);
			if (status !== 1'b0) n_wk++;
		end
		check("status off", 16'(n_wk), 16'h0000);
		rd_chk("flag off", 8'h01, 8'h00);
		episode(12'hFFF);
		bus_write(8'h00, {5'h02, code});
		repeat (4) @(posedge clk_i);
		idle_i <= 1'b1;
		episode(12'h400);
		check("restart", 16'(t_wk - t_st inside {N, N + 1}), 16'h0001);
		// A write while the clock enable is low must be refused.
		@(posedge clk_i);
		ce_i <= 1'b0;
		bus_write(8'h02, 8'h00);
		ce_i <= 1'b1;
		rd_chk("frozen mask", 8'h02, 8'h01);
		tally_and_finish();
	end
endmodule : tb_vdet_ctrl
